// ---- design/bus_ctrl_map.vh ----
// Overview of operation
// [RULE_01] power-good inactive drives both processor and system reset active.
// [RULE_02] warm reset request pulses only the processor reset.
// [RULE_03] processor shutdown fires processor reset, timed on processor clock edges.
// [RULE_04] each processor reset lasts at least 16 processor clocks, then releases.
// [RULE_05] software reset bit rising fires processor reset once the I/O command ends.
// [RULE_06] system reset follows power-good low, released on processor clock.
// [RULE_07] processor clock comes from fast oscillator or bus clock per selection.
// [RULE_08] phase clock runs at half the processor clock rate.
// [RULE_09] bus system clock is always half the bus state-machine clock.
// [RULE_10] synchronous mode: both clocks from oscillator, three rate combinations.
// [RULE_11] asynchronous mode: bus state-machine clock equals bus clock input.
// [RULE_12] software writes source-select bits first, then the clock switch bit.
// [RULE_13] after reset processor clock is oscillator, bus system clock a quarter.
// [RULE_14] no processor clock phase is shortened during a switch; the low phase is stretched while parked.
// [RULE_15] fast-to-slow: fall latches command, next fall parks clock low.
// [RULE_16] slow source rise latches park, its next fall connects slow source.
// [RULE_17] if processor clock still seen high, wait another slow edge.
// [RULE_18] slow-to-fast: rise latches command, next edge disconnects slow source.
// [RULE_19] oscillator samples clock low then connects; one extra edge on a miss.
// [RULE_20] software keeps oscillator as processor clock except for slowed code.
// [RULE_21] clock-select controls pass two flip-flop stages before use.
`ifndef BUS_CTRL_MAP_VH
`define BUS_CTRL_MAP_VH

`define CPU_RESET_CYCLES     5'd16
`define SEL_BUS_SRC_BIT      0
`define SEL_HALF_BIT         1
`define SEL_SWITCH_BIT       2
`define SEL_RESET            2'b10
`define SWITCH_RESET         1'b0
`define CTL_WIDTH            3

`endif

// ---- design/ctl_sync.v ----
`timescale 1ns/10ps
`default_nettype none
module ctl_sync #(
   parameter WIDTH = 3
) (
   input  wire             clk,
   input  wire             rst_b,
   input  wire [WIDTH-1:0] d,
   input  wire [WIDTH-1:0] reset_value,
   output reg  [WIDTH-1:0] q
);
   reg [WIDTH-1:0] stage1;
   reg             loaded;

   // first stage is read by the second stage only
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= {WIDTH{1'b0}};
         q      <= {WIDTH{1'b0}};
         loaded <= 1'b0;
      end else begin
         stage1 <= d;
         loaded <= 1'b1;
         // reset value caught by the clock after release, never by the reset branch
         q      <= loaded ? stage1 : reset_value;
      end
   end
endmodule // ctl_sync
`default_nettype wire

// ---- design/level_edges.v ----
`timescale 1ns/10ps
`default_nettype none
module level_edges (
   input  wire clk,
   input  wire rst_b,
   input  wire lvl,
   output reg  q,
   output wire rise,
   output wire fall
);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= 1'b0;
      end else begin
         q <= lvl;
      end
   end

   assign rise = lvl & ~q;
   assign fall = ~lvl & q;
endmodule // level_edges
`default_nettype wire

// ---- design/bus_ctrl_reset_clock_select.v ----
`timescale 1ns/10ps
`default_nettype none
`include "bus_ctrl_map.vh"
module bus_ctrl_reset_clock_select (
   input  wire       clk,
   input  wire       rst_b,
   input  wire       power_good_in,
   input  wire       warm_reset_in,
   input  wire       shutdown_in,
   input  wire       software_cpu_reset_bit,
   input  wire       io_command_active,
   input  wire       fast_osc_in,
   input  wire       bus_clock_in,
   input  wire [1:0] clock_source_select_bits,
   input  wire       clock_switch_bit,
   output reg        cpu_reset_out,
   output reg        system_reset_out,
   output reg        processor_clock,
   output reg        phase_clock,
   output reg        bus_sm_clock,
   output reg        bus_system_clock,
   output reg        processor_on_slow
);
   // one-hot switch states: fs_* fast to slow, sf_* slow to fast
   localparam [7:0] ST_FAST     = 8'h01;
   localparam [7:0] ST_FS_LATCH = 8'h02;
   localparam [7:0] ST_FS_PARK  = 8'h04;
   localparam [7:0] ST_FS_SEEN  = 8'h08;
   localparam [7:0] ST_SLOW     = 8'h10;
   localparam [7:0] ST_SF_LATCH = 8'h20;
   localparam [7:0] ST_SF_PARK  = 8'h40;
   localparam [7:0] ST_SF_SEEN  = 8'h80;
   localparam [1:0] SEL_DEFAULT = `SEL_RESET;

   function rising;
      input now_lvl;
      input was_lvl;
      begin
         rising = now_lvl & ~was_lvl;
      end
   endfunction

   wire                  fast_q;
   wire                  fast_rise;
   wire                  fast_fall;
   wire                  bus_q;
   wire                  bus_rise;
   wire                  bus_fall;
   wire [`CTL_WIDTH-1:0] ctl_q;

   reg  [7:0] state;
   reg  [7:0] next_state;
   reg        osc_half;
   reg        cfg_async;
   reg        cfg_half;
   reg        cfg_slow;
   reg        switch_seen;
   reg        cfg_pending;
   reg        sw_bit_prev;
   reg        sw_reset_pending;
   reg  [4:0] reset_count;
   reg        next_processor_clock;
   reg        next_bus_sm_clock;

   wire half_next;
   wire half_rise;
   wire half_fall;
   wire slow_next;
   wire slow_rise;
   wire slow_fall;
   wire proc_rise;
   wire stable;
   wire cmd_trigger;

   // sources are sampled by clk, so edges show one clk late; the park
   // phases absorb that delay
   level_edges u_fast_edges (
      .clk   (clk),
      .rst_b (rst_b),
      .lvl   (fast_osc_in),
      .q     (fast_q),
      .rise  (fast_rise),
      .fall  (fast_fall)
   );

   level_edges u_bus_edges (
      .clk   (clk),
      .rst_b (rst_b),
      .lvl   (bus_clock_in),
      .q     (bus_q),
      .rise  (bus_rise),
      .fall  (bus_fall)
   );

   // select and switch bits come from the register side: two flops first
   ctl_sync #(
      .WIDTH (`CTL_WIDTH)
   ) u_ctl_sync (
      .clk         (clk),
      .rst_b       (rst_b),
      .d           ({clock_switch_bit, clock_source_select_bits}),
      .reset_value ({`SWITCH_RESET, `SEL_RESET}),
      .q           (ctl_q)
   ); // [RULE_21]

   // oscillator divided by two, shared by the half-rate sync modes
   assign half_next = osc_half ^ fast_rise;
   assign half_rise = fast_rise & ~osc_half;
   assign half_fall = fast_rise & osc_half;

   // slow source is the bus clock in async mode, else oscillator halved
   assign slow_next = cfg_async ? bus_clock_in : half_next; // [RULE_07]
   assign slow_rise = cfg_async ? bus_rise : half_rise;
   assign slow_fall = cfg_async ? bus_fall : half_fall;

   // rise seen as the register loads, one clk ahead of the pin
   assign proc_rise = rising(next_processor_clock, processor_clock);
   // config may only change while no switch is under way
   assign stable    = (state == ST_FAST) || (state == ST_SLOW);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_half <= 1'b0;
      end else begin
         osc_half <= half_next;
      end
   end

   // config is applied only on a switch-bit change, so select bits written
   // earlier take effect together; changes mid-switch wait for a stable state
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_async   <= SEL_DEFAULT[`SEL_BUS_SRC_BIT];
         cfg_half    <= SEL_DEFAULT[`SEL_HALF_BIT];
         cfg_slow    <= `SWITCH_RESET;
         switch_seen <= `SWITCH_RESET;
         cfg_pending <= 1'b0;
      end else begin
         switch_seen <= ctl_q[`SEL_SWITCH_BIT];
         if (ctl_q[`SEL_SWITCH_BIT] != switch_seen) begin
            cfg_pending <= 1'b1; // [RULE_12]
         end else if (cfg_pending && stable) begin
            cfg_pending <= 1'b0;
         end
         // applied a cycle after the change is seen, once the machine is stable
         if (cfg_pending && stable && ctl_q[`SEL_SWITCH_BIT] == switch_seen) begin
            cfg_async <= ctl_q[`SEL_BUS_SRC_BIT]; // [RULE_11]
            cfg_half  <= ctl_q[`SEL_HALF_BIT];    // [RULE_10]
            cfg_slow  <= ctl_q[`SEL_SWITCH_BIT];
         end
      end
   end

   // glitch-free source change: the line is parked low between sources
   always @* begin
      next_state = state;
      case (state)
         ST_FAST: begin
            if (cfg_slow && fast_fall) begin
               next_state = ST_FS_LATCH; // [RULE_15]
            end
         end
         ST_FS_LATCH: begin
            if (fast_fall) begin
               next_state = ST_FS_PARK; // [RULE_15]
            end
         end
         ST_FS_PARK: begin
            if (slow_rise) begin
               next_state = ST_FS_SEEN; // [RULE_16]
            end
         end
         ST_FS_SEEN: begin
            if (slow_fall && !processor_clock) begin
               next_state = ST_SLOW; // [RULE_16]
            end
            // a high sample simply waits for the following edge [RULE_17]
         end
         ST_SLOW: begin
            if (!cfg_slow && slow_rise) begin
               next_state = ST_SF_LATCH; // [RULE_18]
            end
         end
         ST_SF_LATCH: begin
            if (slow_fall) begin
               next_state = ST_SF_PARK; // [RULE_18]
            end
         end
         ST_SF_PARK: begin
            // a low registered clock means the park already reached the pin
            if ((fast_rise || fast_fall) && !processor_clock) begin
               next_state = ST_SF_SEEN; // [RULE_19]
            end
         end
         ST_SF_SEEN: begin
            // connecting on a fall keeps the first high phase full length
            if (fast_fall) begin
               next_state = ST_FAST; // [RULE_19]
            end
         end
         default: begin
            // a corrupt code falls back to the fast source
            next_state = ST_FAST;
         end
      endcase
   end

   always @* begin
      case (state)
         ST_FAST, ST_FS_LATCH: begin
            next_processor_clock = fast_osc_in; // [RULE_07]
         end
         ST_SLOW, ST_SF_LATCH: begin
            next_processor_clock = slow_next; // [RULE_07]
         end
         default: begin
            next_processor_clock = 1'b0; // [RULE_14]
         end
      endcase
      if (cfg_async) begin
         next_bus_sm_clock = bus_clock_in; // [RULE_11]
      end else if (cfg_half || cfg_slow) begin
         // either half-rate sync mode runs the bus machine off the halved oscillator
         next_bus_sm_clock = half_next; // [RULE_10]
      end else begin
         next_bus_sm_clock = fast_osc_in; // [RULE_10]
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // every clock leaves through a flop, so no pin can glitch
         state             <= ST_FAST; // [RULE_13]
         processor_clock   <= 1'b0;
         bus_sm_clock      <= 1'b0;
         phase_clock       <= 1'b0;
         bus_system_clock  <= 1'b0;
         processor_on_slow <= 1'b0;
      end else begin
         state             <= next_state;
         processor_clock   <= next_processor_clock;
         bus_sm_clock      <= next_bus_sm_clock;
         processor_on_slow <= (next_state == ST_SLOW) || (next_state == ST_SF_LATCH);
         if (proc_rise) begin
            phase_clock <= ~phase_clock; // [RULE_08]
         end
         if (rising(next_bus_sm_clock, bus_sm_clock)) begin
            bus_system_clock <= ~bus_system_clock; // [RULE_09]
         end
      end
   end

   // software reset: armed by a rising bit, fired once the I/O command ends
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_bit_prev      <= 1'b0;
         sw_reset_pending <= 1'b0;
      end else begin
         sw_bit_prev <= software_cpu_reset_bit;
         if (rising(software_cpu_reset_bit, sw_bit_prev)) begin
            sw_reset_pending <= 1'b1; // [RULE_05]
         end else if (!io_command_active && proc_rise) begin
            // kept until it fires; dropping it when the command ends would
            // lose a reset that falls between processor clock rises
            sw_reset_pending <= 1'b0;
         end
      end
   end

   // shutdown and warm reset are taken on processor clock edges so the
   // reset reaches the processor aligned with its clock
   assign cmd_trigger = proc_rise &&
                        (shutdown_in || warm_reset_in || // [RULE_03] [RULE_02]
                         (sw_reset_pending && !io_command_active)); // [RULE_05]

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reset_count      <= `CPU_RESET_CYCLES;
         cpu_reset_out    <= 1'b1;
         system_reset_out <= 1'b1;
      end else begin
         // every trigger reloads the count, so a held request stretches reset
         if (!power_good_in) begin
            reset_count   <= `CPU_RESET_CYCLES; // [RULE_01]
            cpu_reset_out <= 1'b1;
         end else if (cmd_trigger) begin
            reset_count   <= `CPU_RESET_CYCLES; // [RULE_04]
            cpu_reset_out <= 1'b1;
         end else if (proc_rise && reset_count != 5'd0) begin
            reset_count   <= reset_count - 5'd1; // [RULE_04]
            cpu_reset_out <= (reset_count != 5'd1);
         end
         // only power-good sets it; warm and software resets leave it alone
         if (!power_good_in) begin
            system_reset_out <= 1'b1; // [RULE_01]
         end else if (proc_rise) begin
            system_reset_out <= 1'b0; // [RULE_06]
         end
      end
   end
endmodule // bus_ctrl_reset_clock_select
`default_nettype wire

// ---- sim/osc_pair_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// both sources run free like crystal oscillators; unequal halves keep their phases drifting
module osc_pair_model #(
   parameter int FAST_HALF = 3,
   parameter int SLOW_HALF = 5
) (
   input  wire logic clk,
   output var  logic fast_osc_in,
   output var  logic bus_clock_in
);
   int fast_cnt;
   int slow_cnt;

   initial begin
      fast_cnt = 0;
      slow_cnt = 0;
      fast_osc_in = 1'b0;
      bus_clock_in = 1'b0;
   end

   always @(negedge clk) begin
      fast_cnt <= (fast_cnt == FAST_HALF - 1) ? 0 : fast_cnt + 1;
      slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
      if (fast_cnt == FAST_HALF - 1) fast_osc_in <= ~fast_osc_in;
      if (slow_cnt == SLOW_HALF - 1) bus_clock_in <= ~bus_clock_in;
   end
endmodule // osc_pair_model
`default_nettype wire

// ---- sim/bus_ctrl_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module bus_ctrl_properties (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       power_good_in,
   input wire logic       warm_reset_in,
   input wire logic       shutdown_in,
   input wire logic [1:0] clock_source_select_bits,
   input wire logic       cpu_reset_out,
   input wire logic       system_reset_out,
   input wire logic       processor_clock,
   input wire logic       phase_clock,
   input wire logic       bus_sm_clock,
   input wire logic       bus_system_clock,
   input wire logic       processor_on_slow
);
   logic [4:0] rises;
   logic       prev_rise;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // saturates so a long held reset cannot wrap the count
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rises <= 5'h00;
         prev_rise <= 1'b0;
      end else begin
         prev_rise <= $rose(processor_clock);
         if (!cpu_reset_out) rises <= 5'h00;
         else if ($rose(processor_clock) && rises != 5'h1f) rises <= rises + 5'h01;
      end
   end

   sequence sm_up;
      bus_sm_clock && !$past(bus_sm_clock);
   endsequence
   sequence handover;
      $changed(processor_on_slow);
   endsequence

   power_low_resets_a: assert property (!power_good_in |=> cpu_reset_out && system_reset_out)
      else $error("power low without both resets");
   sys_rise_cause_a: assert property ($rose(system_reset_out) |-> !$past(power_good_in))
      else $error("system reset raised without power low");
   sys_release_a: assert property ($fell(system_reset_out) |-> power_good_in && ($rose(processor_clock) || prev_rise))
      else $error("system reset released off processor clock");
   cpu_rise_cause_a: assert property ($rose(cpu_reset_out) |-> $rose(processor_clock) || prev_rise
      || !$past(power_good_in) || !$past(power_good_in, 2))
      else $error("processor reset raised off processor clock");
   warm_fires_a: assert property ($rose(processor_clock) && power_good_in && ($past(warm_reset_in) || $past(shutdown_in))
      |-> ##[0:2] cpu_reset_out)
      else $error("request did not raise processor reset");
   reset_width_a: assert property ($fell(cpu_reset_out) |-> rises >= 5'h0f)
      else $error("processor reset too short");
   no_short_phase_a: assert property ($changed(processor_clock) |=> $stable(processor_clock))
      else $error("processor clock phase of one cycle");
   clean_switch_a: assert property (handover |-> !processor_clock)
      else $error("source changed while processor clock high");
   bus_system_clock_half_a: assert property (sm_up |-> ##[0:1] $changed(bus_system_clock))
      else $error("bus system clock missed a toggle");
   phase_half_a: assert property ($changed(phase_clock) |-> $rose(processor_clock) || prev_rise)
      else $error("phase clock toggled off processor rise");
endmodule // bus_ctrl_properties

bind bus_ctrl_reset_clock_select bus_ctrl_properties chk (.clk(clk), .rst_b(rst_b), .power_good_in(power_good_in),
   .warm_reset_in(warm_reset_in), .shutdown_in(shutdown_in), .clock_source_select_bits(clock_source_select_bits),
   .cpu_reset_out(cpu_reset_out), .system_reset_out(system_reset_out), .processor_clock(processor_clock),
   .phase_clock(phase_clock), .bus_sm_clock(bus_sm_clock), .bus_system_clock(bus_system_clock),
   .processor_on_slow(processor_on_slow));
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic       clk, rst_b, power_good_in, warm_reset_in, shutdown_in;
   logic       software_cpu_reset_bit, io_command_active, clock_switch_bit;
   logic [1:0] clock_source_select_bits;
   wire        fast_osc_in, bus_clock_in, cpu_reset_out, system_reset_out, processor_clock;
   wire        phase_clock, bus_sm_clock, bus_system_clock, processor_on_slow;
   int         err_total = 0;
   int         comparisons = 0;

   osc_pair_model osc (.clk(clk), .fast_osc_in(fast_osc_in), .bus_clock_in(bus_clock_in));
   bus_ctrl_reset_clock_select dut (.clk(clk), .rst_b(rst_b), .power_good_in(power_good_in),
      .warm_reset_in(warm_reset_in), .shutdown_in(shutdown_in), .software_cpu_reset_bit(software_cpu_reset_bit),
      .io_command_active(io_command_active), .fast_osc_in(fast_osc_in), .bus_clock_in(bus_clock_in),
      .clock_source_select_bits(clock_source_select_bits), .clock_switch_bit(clock_switch_bit),
      .cpu_reset_out(cpu_reset_out), .system_reset_out(system_reset_out), .processor_clock(processor_clock),
      .phase_clock(phase_clock), .bus_sm_clock(bus_sm_clock), .bus_system_clock(bus_system_clock),
      .processor_on_slow(processor_on_slow));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic tally_and_finish();
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask

   task automatic chkn(input int got, input int exp, input string what);
      comparisons++;
      if (got != exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %0d", $time, what, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // which 0 waits on processor reset, 1 on the slow-source flag
   task automatic wait_for(input int which, input logic lvl);
      for (int k = 0; k < 400; k++) begin
         @(negedge clk);
         if ((which == 0 ? cpu_reset_out : processor_on_slow) === lvl) return;
      end
      err_total++;
      $display("CHECK FAILED %0t wait timed out", $time);
      tally_and_finish();
   endtask

   task automatic follow(input logic slow, input string what);
      repeat (24) begin
         @(negedge clk);
         chk1(processor_clock, slow ? bus_clock_in : fast_osc_in, what);
      end
   endtask

   // which 0 processor clock, 1 bus system clock, 2 phase clock, 3 bus machine clock
   function automatic logic pick(input int which);
      return which == 0 ? processor_clock : which == 1 ? bus_system_clock :
             which == 2 ? phase_clock : bus_sm_clock;
   endfunction

   // rises of the picked clock over 48 cycles
   task automatic count_rises(input int which, output int n);
      logic prev, now;
      n = 0;
      prev = pick(which);
      repeat (48) begin
         @(negedge clk);
         now = pick(which);
         if (now && !prev) n++;
         prev = now;
      end
   endtask

   task automatic clock_scn();
      int n;
      follow(1'b0, "default fast source");
      count_rises(1, n);
      chkn(n, 2, "default bus system clock rate");
      count_rises(2, n);
      chkn(n, 4, "phase clock rate");
      count_rises(3, n);
      chkn(n, 4, "default bus machine clock rate");
      clock_source_select_bits = 2'b01;
      tick(4);
      clock_switch_bit = 1'b1;
      wait_for(1, 1'b1);
      tick(2);
      follow(1'b1, "slow source");
      clock_switch_bit = 1'b0;
      wait_for(1, 1'b0);
      tick(12);
      follow(1'b0, "back to fast");
      clock_source_select_bits = 2'b10;
      tick(4);
      clock_switch_bit = 1'b1;
      wait_for(1, 1'b1);
      tick(2);
      count_rises(0, n);
      chkn(n, 4, "half rate processor clock");
      clock_switch_bit = 1'b0;
      wait_for(1, 1'b0);
   endtask

   task automatic power_good_scn();
      power_good_in = 1'b0;
      tick(10);
      chk1(cpu_reset_out, 1'b1, "cpu reset with power low");
      chk1(system_reset_out, 1'b1, "system reset with power low");
      power_good_in = 1'b1;
      tick(10);
      chk1(system_reset_out, 1'b0, "system reset release");
      wait_for(0, 1'b0);
   endtask

   // request held 6 cycles spans exactly one processor clock rise
   task automatic pulse_scn(input logic shut);
      int n;
      logic prev, seen;
      n = 0;
      seen = 1'b0;
      prev = processor_clock;
      warm_reset_in = !shut;
      shutdown_in = shut;
      for (int k = 0; k < 400; k++) begin
         @(negedge clk);
         if (k == 5) begin
            warm_reset_in = 1'b0;
            shutdown_in = 1'b0;
         end
         if (seen && processor_clock && !prev) n++;
         if (cpu_reset_out === 1'b1) seen = 1'b1;
         else if (seen) break;
         prev = processor_clock;
      end
      chkn(n, 16, "cpu reset length");
      chk1(system_reset_out, 1'b0, "system reset stays off");
   endtask

   task automatic sw_scn();
      io_command_active = 1'b1;
      software_cpu_reset_bit = 1'b1;
      tick(30);
      chk1(cpu_reset_out, 1'b0, "reset held during io command");
      io_command_active = 1'b0;
      tick(12);
      chk1(cpu_reset_out, 1'b1, "software reset fired");
      software_cpu_reset_bit = 1'b0;
      wait_for(0, 1'b0);
   endtask

   initial begin
      rst_b = 1'b0;
      power_good_in = 1'b1;
      warm_reset_in = 1'b0;
      shutdown_in = 1'b0;
      software_cpu_reset_bit = 1'b0;
      io_command_active = 1'b0;
      clock_switch_bit = 1'b0;
      clock_source_select_bits = 2'b10;
      tick(12);
      rst_b = 1'b1;
      tick(2);
      chk1(cpu_reset_out, 1'b1, "processor reset after power-up");
      wait_for(0, 1'b0);
      clock_scn();
      power_good_scn();
      pulse_scn(1'b0);
      pulse_scn(1'b1);
      sw_scn();
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
